// File: rtl/cub_buffers.sv
// What this block does
// - Holds 384 status bits plus 384 user bits
// - Two cascaded buffers; transmit loads whole blocks
// - Staging-to-transmit copy happens on output block timing
// - Byte MSB is earliest bit; byte 0 at 20h
// - Staging buffer host readable and writable; transmit hidden
// - Enabled interrupt raised on every block transfer
// - Inhibit bit blocks every staging-to-transmit transfer
// - Professional blocks get the check byte computed
// - Status staging is 24 words; A high, B low
// - Control bit picks single or paired byte access
// - Single-byte read returns A or B per select
// - Single-byte write stores the byte to both halves
// - Paired read gives A byte then B byte
// - User mode 1 sends zero in every user bit
// - User mode 2 double-buffers user data like status
// - User staging access is always paired
// - User word interleaves A7,B7 down to A0,B0
`timescale 1ns/1ps
`default_nettype none
module cub_buffers
    import cub_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               cp_start,
    input  wire logic [ADDR_W-1:0]  cp_addr,
    input  wire logic               cp_wr,
    input  wire logic [BYTE_W-1:0]  cp_wdata,
    output logic                    cp_wr_ready,
    input  wire logic               cp_rd,
    output logic                    cp_rd_ready,
    output logic      [BYTE_W-1:0]  cp_rdata,
    output logic                    cp_rvalid,
    input  wire logic               blk_start,
    input  wire logic [FRAME_W-1:0] frame_idx,
    output logic                    cs_bit_a,
    output logic                    cs_bit_b,
    output logic                    user_bit_a,
    output logic                    user_bit_b,
    output logic                    xfer_irq
);
    typedef logic [CS_WORDS-1:0][WORD_W-1:0] cub_blk_t;

    typedef struct packed {
        logic [BYTE_W-1:0] ctrl;
        logic              xfer_done;
        logic              phase;
        cub_blk_t          e_cs;
        cub_blk_t          f_cs;
        cub_blk_t          e_u;
        cub_blk_t          f_u;
        logic [BYTE_W-1:0] rdata;
        logic              rvalid;
        logic              cs_a;
        logic              cs_b;
        logic              u_a;
        logic              u_b;
        logic              irq;
    } cub_state_t;

    cub_state_t q;
    cub_state_t next_q;

    logic       rst_q1;
    logic       rst_n;

    // Reset released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Check byte over bytes 0..22, earliest bit first
    function automatic logic [7:0] cub_crc(input cub_blk_t w, input logic hi);
        logic [7:0] c;
        logic [7:0] b;
        logic       fbk;
        c = CRC_INIT;
        for (int i = 0; i < CRC_BYTE; i++) begin
            b = hi ? w[i][WORD_W-1:BYTE_W] : w[i][BYTE_W-1:0];
            for (int j = BYTE_W - 1; j >= 0; j--) begin
                fbk = c[7] ^ b[j];
                c   = {c[6:0], 1'b0} ^ (fbk ? CRC_POLY : 8'h00);
            end
        end
        return c;
    endfunction

    logic [ADDR_W-1:0] cs_off;
    logic [ADDR_W-1:0] u_off;
    logic              in_cs;
    logic              in_u;
    logic              paired;
    logic              wr_take;
    logic              rd_take;
    logic              copy_now;
    cub_entry_t        push_e;
    cub_entry_t        pop_e;
    logic [ENTRY_W-1:0] pop_raw;
    logic              pop_valid;
    logic              pop_ready;
    logic              fifo_in_ready;
    logic [WIDX_W-1:0] fw;
    logic [2:0]        fb;

    assign cs_off   = cp_addr - ADDR_CS;
    assign u_off    = cp_addr - ADDR_USER;
    assign in_cs    = (cp_addr >= ADDR_CS) && (cs_off < ADDR_W'(WORD_COUNT));
    assign in_u     = (cp_addr >= ADDR_USER) && (u_off < ADDR_W'(WORD_COUNT));
    assign paired   = in_u | (in_cs & q.ctrl[CTRL_TWO]);

    // Buffer reads wait for queued writes so they see them
    assign cp_wr_ready = fifo_in_ready;
    assign cp_rd_ready = ~pop_valid;
    assign wr_take     = cp_wr & fifo_in_ready;
    assign rd_take     = cp_rd & ~cp_wr & ~pop_valid;

    // Transfer only at an output block edge, never under inhibit
    assign copy_now  = blk_start & ~q.ctrl[CTRL_INHIB];
    // Staging updates stall in the copy cycle to keep it atomic
    assign pop_ready = ~copy_now;
    assign pop_e     = cub_entry_t'(pop_raw);

    always_comb begin
        push_e         = '0;
        push_e.is_user = in_u;
        push_e.widx    = in_u ? u_off[WIDX_W-1:0] : cs_off[WIDX_W-1:0];
        push_e.we_a    = ~paired | ~q.phase;
        push_e.we_b    = ~paired | q.phase;
        push_e.data    = cp_wdata;
    end

    cub_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .in_valid  (cp_wr & (in_cs | in_u)),
        .in_ready  (fifo_in_ready),
        .in_data   (push_e),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_raw)
    );

    assign fw = frame_idx[FRAME_W-1:3];
    assign fb = 3'h7 - frame_idx[2:0];

    always_comb begin
        next_q        = q;
        next_q.rvalid = 1'b0;

        // Byte phase restarts with every control port transaction
        if (cp_start) begin
            next_q.phase = 1'b0;
        end else if ((wr_take | rd_take) & paired) begin
            next_q.phase = ~q.phase;
        end

        if (wr_take && cp_addr == ADDR_CTRL) begin
            next_q.ctrl = cp_wdata;
        end
        if (wr_take && cp_addr == ADDR_STAT && cp_wdata[STAT_XFER]) begin
            next_q.xfer_done = 1'b0;
        end

        if (rd_take) begin
            next_q.rvalid = 1'b1;
            next_q.rdata  = '0;
            if (cp_addr == ADDR_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (cp_addr == ADDR_STAT) begin
                next_q.rdata[STAT_XFER] = q.xfer_done;
            end else if (in_cs) begin
                if (paired ? ~q.phase : ~q.ctrl[CTRL_SEL_B]) begin
                    next_q.rdata = q.e_cs[cs_off[WIDX_W-1:0]][WORD_W-1:BYTE_W];
                end else begin
                    next_q.rdata = q.e_cs[cs_off[WIDX_W-1:0]][BYTE_W-1:0];
                end
            end else if (in_u) begin
                if (~q.phase) begin
                    next_q.rdata = q.e_u[u_off[WIDX_W-1:0]][WORD_W-1:BYTE_W];
                end else begin
                    next_q.rdata = q.e_u[u_off[WIDX_W-1:0]][BYTE_W-1:0];
                end
            end
        end

        // Queued writes land in staging; A is the high byte
        if (pop_valid & pop_ready) begin
            if (pop_e.is_user) begin
                if (pop_e.we_a) begin
                    next_q.e_u[pop_e.widx][WORD_W-1:BYTE_W] = pop_e.data;
                end
                if (pop_e.we_b) begin
                    next_q.e_u[pop_e.widx][BYTE_W-1:0] = pop_e.data;
                end
            end else begin
                if (pop_e.we_a) begin
                    next_q.e_cs[pop_e.widx][WORD_W-1:BYTE_W] = pop_e.data;
                end
                if (pop_e.we_b) begin
                    next_q.e_cs[pop_e.widx][BYTE_W-1:0] = pop_e.data;
                end
            end
        end

        // Whole-block copy; staging is kept, so inhibited writes wait
        if (copy_now) begin
            next_q.f_cs = q.e_cs;
            next_q.f_u  = q.e_u;
            if (q.e_cs[0][BYTE_W + PRO_BIT]) begin
                next_q.f_cs[CRC_BYTE][WORD_W-1:BYTE_W] = cub_crc(q.e_cs, 1'b1);
            end
            if (q.e_cs[0][PRO_BIT]) begin
                next_q.f_cs[CRC_BYTE][BYTE_W-1:0] = cub_crc(q.e_cs, 1'b0);
            end
            // Set placed after the clear so a same-cycle event wins
            next_q.xfer_done = 1'b1;
        end

        next_q.irq = q.xfer_done & q.ctrl[CTRL_IRQ_EN];

        // Encoder taps; frames past the block read as zero
        next_q.cs_a = 1'b0;
        next_q.cs_b = 1'b0;
        next_q.u_a  = 1'b0;
        next_q.u_b  = 1'b0;
        if (fw < WIDX_W'(WORD_COUNT)) begin
            next_q.cs_a = q.f_cs[fw][BYTE_W + 32'(fb)];
            next_q.cs_b = q.f_cs[fw][32'(fb)];
            if (q.ctrl[CTRL_UBLK]) begin
                next_q.u_a = q.f_u[fw][2 * 32'(fb) + 1];
                next_q.u_b = q.f_u[fw][2 * 32'(fb)];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign cp_rdata   = q.rdata;
    assign cp_rvalid  = q.rvalid;
    assign cs_bit_a   = q.cs_a;
    assign cs_bit_b   = q.cs_b;
    assign user_bit_a = q.u_a;
    assign user_bit_b = q.u_b;
    assign xfer_irq   = q.irq;
endmodule // cub_buffers
`default_nettype wire

// File: rtl/cub_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cub_fifo
    import cub_pkg::*;
#(
    parameter int WIDTH = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } cub_fifo_state_t;

    cub_fifo_state_t q;
    cub_fifo_state_t next_q;
    logic            push;
    logic            pop;

    assign in_ready  = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wp] = in_data;
            next_q.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end
        if (pop) begin
            next_q.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
        end
        // Simultaneous push and pop leave the count alone
        next_q.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule // cub_fifo
`default_nettype wire

// File: rtl/cub_pkg.sv
package cub_pkg;
    localparam int            CS_WORDS    = 24;
    localparam int            WORD_W      = 16;
    localparam int            BYTE_W      = 8;
    localparam int            ADDR_W      = 7;
    localparam int            WIDX_W      = 5;
    localparam int            FRAME_W     = 8;
    localparam int            FIFO_DEPTH  = 16;
    localparam int            ENTRY_W     = 16;
    localparam logic [6:0]    ADDR_CTRL   = 7'h01;
    localparam logic [6:0]    ADDR_STAT   = 7'h02;
    localparam logic [6:0]    ADDR_CS     = 7'h20;
    localparam logic [6:0]    ADDR_USER   = 7'h38;
    localparam int            CTRL_INHIB  = 0;
    localparam int            CTRL_TWO    = 1;
    localparam int            CTRL_SEL_B  = 2;
    localparam int            CTRL_UBLK   = 3;
    localparam int            CTRL_IRQ_EN = 4;
    localparam logic [7:0]    CTRL_RESET  = 8'h00;
    localparam int            STAT_XFER   = 0;
    localparam int            PRO_BIT     = 7;
    localparam int            CRC_BYTE    = 23;
    localparam logic [7:0]    CRC_POLY    = 8'h1d;
    localparam logic [7:0]    CRC_INIT    = 8'hff;
    localparam logic [5:0]    WORD_COUNT  = 6'h18;

    typedef struct packed {
        logic                 is_user;
        logic [WIDX_W-1:0]    widx;
        logic                 we_a;
        logic                 we_b;
        logic [BYTE_W-1:0]    data;
    } cub_entry_t;
endpackage

// File: verification/cub_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cub_checker
    import cub_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst_b,
    input wire logic [ADDR_W-1:0]  cp_addr,
    input wire logic               cp_wr,
    input wire logic               cp_wr_ready,
    input wire logic               cp_rd,
    input wire logic               cp_rd_ready,
    input wire logic [BYTE_W-1:0]  cp_rdata,
    input wire logic               cp_rvalid,
    input wire logic               blk_start,
    input wire logic [FRAME_W-1:0] frame_idx,
    input wire logic               cs_bit_a,
    input wire logic               cs_bit_b,
    input wire logic               xfer_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_RD_ANSWER: assert property (cp_rd && !cp_wr && cp_rd_ready |=> cp_rvalid)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (cp_rvalid |-> $past(cp_rd && !cp_wr && cp_rd_ready))
        else $error("read answer without request");
    AST_RDATA_HOLD: assert property (!cp_rvalid |-> $stable(cp_rdata))
        else $error("read data moved without a read");
    AST_READY_ORDER: assert property (cp_rd_ready |-> cp_wr_ready)
        else $error("empty queue refuses writes");
    AST_WRITE_QUEUED: assert property (cp_wr && cp_wr_ready && cp_addr inside {[ADDR_CS:7'h4f]} |=> !cp_rd_ready)
        else $error("buffer write not queued");
    // Transmit side may only change on a transfer
    AST_TX_STEADY: assert property ($stable(frame_idx) && !$past(blk_start) |=> $stable({cs_bit_a, cs_bit_b}))
        else $error("transmit bits changed without transfer");
    AST_IRQ_RISE: assert property ($rose(xfer_irq) |-> $past(blk_start, 2) || $past(cp_wr, 2))
        else $error("interrupt without transfer");
    AST_IRQ_FALL: assert property ($fell(xfer_irq) |-> $past(cp_wr, 2))
        else $error("interrupt dropped without host write");
endmodule // cub_checker
bind cub_buffers cub_checker i_cub_checker (.core_clk(core_clk), .rst_b(rst_b), .cp_addr(cp_addr),
    .cp_wr(cp_wr), .cp_wr_ready(cp_wr_ready), .cp_rd(cp_rd), .cp_rd_ready(cp_rd_ready),
    .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .blk_start(blk_start), .frame_idx(frame_idx),
    .cs_bit_a(cs_bit_a), .cs_bit_b(cs_bit_b), .xfer_irq(xfer_irq));
`default_nettype wire

// File: verification/cub_host.sv
`timescale 1ns/1ps
`default_nettype none
module cub_host
    import cub_pkg::*;
(
    input  wire logic              core_clk,
    output logic                   cp_start,
    output logic      [ADDR_W-1:0] cp_addr,
    output logic                   cp_wr,
    output logic      [BYTE_W-1:0] cp_wdata,
    input  wire logic              cp_wr_ready,
    output logic                   cp_rd,
    input  wire logic              cp_rd_ready,
    input  wire logic [BYTE_W-1:0] cp_rdata
);
    initial begin
        {cp_start, cp_wr, cp_rd, cp_addr, cp_wdata} = '0;
    end
    task start();
        @(posedge core_clk) #1;
        cp_start = 1'b1;
        @(posedge core_clk) #1;
        cp_start = 1'b0;
    endtask
    // Paired callers give the A byte first, new blocks after a transfer
    task wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
        @(posedge core_clk) #1;
        cp_addr = a;
        cp_wdata = d;
        cp_wr = 1'b1;
        while (!cp_wr_ready) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        cp_wr = 1'b0;
        cp_wdata = ~d;
    endtask
    task rd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d);
        @(posedge core_clk) #1;
        cp_addr = a;
        cp_rd = 1'b1;
        while (!cp_rd_ready) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        cp_rd = 1'b0;
        cp_addr = ~a;
        d = cp_rdata;
    endtask
endmodule // cub_host
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import cub_pkg::*;
;
    logic core_clk = 1'b0, rst_b = 1'b0, blk_start = 1'b0;
    logic [FRAME_W-1:0] frame_idx = '0;
    logic cp_start, cp_wr, cp_rd, cp_wr_ready, cp_rd_ready, cp_rvalid;
    logic [ADDR_W-1:0] cp_addr;
    logic [BYTE_W-1:0] cp_wdata, cp_rdata, d;
    logic cs_bit_a, cs_bit_b, user_bit_a, user_bit_b, xfer_irq;
    logic [3:0] v;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    cub_buffers i_cub_buffers (.core_clk(core_clk), .rst_b(rst_b), .cp_start(cp_start), .cp_addr(cp_addr),
        .cp_wr(cp_wr), .cp_wdata(cp_wdata), .cp_wr_ready(cp_wr_ready), .cp_rd(cp_rd),
        .cp_rd_ready(cp_rd_ready), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .blk_start(blk_start),
        .frame_idx(frame_idx), .cs_bit_a(cs_bit_a), .cs_bit_b(cs_bit_b), .user_bit_a(user_bit_a),
        .user_bit_b(user_bit_b), .xfer_irq(xfer_irq));
    cub_host i_cub_host (.core_clk(core_clk), .cp_start(cp_start), .cp_addr(cp_addr), .cp_wr(cp_wr),
        .cp_wdata(cp_wdata), .cp_wr_ready(cp_wr_ready), .cp_rd(cp_rd), .cp_rd_ready(cp_rd_ready),
        .cp_rdata(cp_rdata));
    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        i_cub_host.rd(a, d);
        chk("rdata", {8'h00, e}, {8'h00, d});
        chk("rvalid", 16'h0001, {15'h0, cp_rvalid});
    endtask
    task ichk(input logic e);
        chk("irq", {15'h0, e}, {15'h0, xfer_irq});
    endtask
    // Waits for the queue to drain so the block is complete
    task blk();
        @(posedge core_clk) #1;
        while (!cp_rd_ready) @(posedge core_clk) #1;
        blk_start = 1'b1;
        @(posedge core_clk) #1;
        blk_start = 1'b0;
        @(posedge core_clk) #1;
    endtask
    task bits(input logic [7:0] f);
        frame_idx = f;
        @(posedge core_clk) #1;
        v = {cs_bit_a, cs_bit_b, user_bit_a, user_bit_b};
    endtask
    task chkb(input logic [7:0] f, input logic [7:0] ea, input logic [7:0] eb);
        for (int i = 0; i < 8; i++) begin
            bits(f + 8'(i));
            chk("cs", {14'h0, ea[7-i], eb[7-i]}, {14'h0, v[3:2]});
        end
    endtask
    function automatic logic [7:0] crc(input logic [7:0] b1);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 23; i++) begin
            c ^= (i == 0) ? 8'h80 : (i == 1) ? b1 : (i == 2) ? 8'hff : 8'h00;
            for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task t_reset();
        rchk(ADDR_CTRL, CTRL_RESET);
        rchk(ADDR_CS, 8'h00);
        rchk(7'h7f, 8'h00);
        $display("reset test done");
    endtask
    task t_two_byte();
        i_cub_host.wr(ADDR_CTRL, 8'h02);
        i_cub_host.start();
        i_cub_host.wr(7'h21, 8'h3c);
        i_cub_host.wr(7'h21, 8'hc3);
        i_cub_host.start();
        rchk(7'h21, 8'h3c);
        rchk(7'h21, 8'hc3);
        blk();
        chkb(8'd8, 8'h3c, 8'hc3);
        $display("two-byte test done");
    endtask
    task t_one_byte();
        i_cub_host.wr(ADDR_CTRL, 8'h00);
        i_cub_host.wr(ADDR_CS, 8'ha5);
        rchk(7'h21, 8'h3c);
        i_cub_host.wr(ADDR_CTRL, 8'h04);
        rchk(7'h21, 8'hc3);
        blk();
        chkb(8'd0, 8'ha5, 8'ha5);
        $display("one-byte test done");
    endtask
    task t_inhibit();
        i_cub_host.wr(ADDR_STAT, 8'h01);
        i_cub_host.wr(ADDR_CTRL, 8'h11);
        i_cub_host.rd(7'h22, d);
        i_cub_host.wr(7'h22, d ^ 8'hff);
        blk();
        ichk(1'b0);
        chkb(8'd16, 8'h00, 8'h00);
        i_cub_host.wr(ADDR_CTRL, 8'h10);
        blk();
        ichk(1'b1);
        rchk(ADDR_STAT, 8'h01);
        i_cub_host.wr(ADDR_STAT, 8'h01);
        @(posedge core_clk) #1;
        ichk(1'b0);
        chkb(8'd16, 8'hff, 8'hff);
        $display("inhibit test done");
    endtask
    task t_user();
        i_cub_host.wr(ADDR_CTRL, 8'h00);
        i_cub_host.start();
        i_cub_host.wr(ADDR_USER, 8'h80);
        i_cub_host.wr(ADDR_USER, 8'h40);
        i_cub_host.start();
        rchk(ADDR_USER, 8'h80);
        rchk(ADDR_USER, 8'h40);
        blk();
        bits(8'd0);
        chk("user", 16'h0, {14'h0, v[1:0]});
        i_cub_host.wr(ADDR_CTRL, 8'h08);
        blk();
        bits(8'd0);
        chk("user", 16'h2, {14'h0, v[1:0]});
        bits(8'd4);
        chk("user", 16'h1, {14'h0, v[1:0]});
        $display("user test done");
    endtask
    task t_check_byte();
        i_cub_host.wr(ADDR_CS, 8'h80);
        blk();
        chkb(8'd184, crc(8'h3c), crc(8'hc3));
        $display("check byte test done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_two_byte();
        t_one_byte();
        t_inhibit();
        t_user();
        t_check_byte();
        close_out();
    end
endmodule // tb
`default_nettype wire
